// ==== core/ddr4_cmd_if.sv ====
`timescale 1ns/1ps
interface ddr4_cmd_if;
    logic cke;
    logic cs_n;
    logic act_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] bg;
    logic [1:0] ba;
    logic [13:0] addr;
    logic odt;
    modport ctrl (output cke, cs_n, act_n, ras_n, cas_n, we_n, bg, ba, addr, odt);
    modport dram (input cke, cs_n, act_n, ras_n, cas_n, we_n, bg, ba, addr, odt);
endinterface : ddr4_cmd_if

// ==== core/mrs_controller.sv ====
`timescale 1ns/1ps
`include "mrs_defines.svh"
// Function
// - Write all mode registers after reset
// - Device holds seven mode registers
// - Mode writes never touch array contents
// - Every MRS carries the whole register
// - MRS only when idle and CKE high
// - ODT held low before MRS with termination
// - ODT high again only after tMOD; code frees ODT one cycle after an MRS that turns termination off
// - Termination off: ODT free around MRS
// - Space MRS commands by tMRD
// - Non-MRS commands wait tMOD after MRS
// - Input-function changes wait full update time; code applies the wait only in C_READY, not during init
// - Those features bypass tMRD, use update wait
// - Those features bypass tMOD, use update wait
// - Updates within tMOD except DLL reset
// - Init order MR3,6,5,4,2,1,0
module mrs_controller (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Bank state from the scheduler
    input wire logic banks_idle,
    // Command link
    ddr4_cmd_if.ctrl link
);
    // ********************************************
    // State
    // ********************************************
    mrs_pkg::ctl_st_e st, next_st;
    mrs_pkg::mr_val_t mr_val [`MR_COUNT];
    mrs_pkg::mr_val_t next_mr_val [`MR_COUNT];
    mrs_pkg::mr_val_t mr_sent [`MR_COUNT];
    mrs_pkg::mr_val_t next_mr_sent [`MR_COUNT];
    mrs_pkg::cnt_t mrd_cnt, next_mrd_cnt, mod_cnt, next_mod_cnt, upd_cnt, next_upd_cnt;
    mrs_pkg::mr_sel_t mrs_sel, next_mrs_sel, init_idx, next_init_idx, sel_now;
    logic cke_q, next_cke_q, odt_req, next_odt_req;
    logic pend_mrs, next_pend_mrs, pend_cmd, next_pend_cmd;
    logic refused, next_refused;
    logic [21:0] cmd_word, next_cmd_word;
    logic [31:0] next_prdata;
    logic cs_n, next_cs_n, odt, next_odt;
    logic [3:0] cmd4, next_cmd4;
    logic [3:0] bgba, next_bgba;
    logic [13:0] addr, next_addr;
    logic acc, wr, mapped, rtt_on, mrs_go, cmd_go;
    logic [7:0] off;
    logic [2:0] vidx;
    mrs_pkg::mr_val_t exempt;

    function automatic mrs_pkg::mr_sel_t init_sel(input mrs_pkg::mr_sel_t idx);
        case (idx)
            3'h0: init_sel = 3'h3;
            3'h1: init_sel = 3'h6;
            3'h2: init_sel = 3'h5;
            3'h3: init_sel = 3'h4;
            3'h4: init_sel = 3'h2;
            3'h5: init_sel = 3'h1;
            default: init_sel = 3'h0;
        endcase
    endfunction : init_sel

    function automatic mrs_pkg::mr_val_t exempt_mask(input mrs_pkg::mr_sel_t s);
        case (s)
            3'h1: exempt_mask = `MR1_EXEMPT;
            3'h3: exempt_mask = `MR3_EXEMPT;
            3'h4: exempt_mask = `MR4_EXEMPT;
            3'h5: exempt_mask = `MR5_EXEMPT;
            3'h6: exempt_mask = `MR6_EXEMPT;
            default: exempt_mask = 14'h0000;
        endcase
    endfunction : exempt_mask

    // ********************************************
    // Decode
    // ********************************************
    assign off = paddr[7:0];
    assign vidx = 3'((off - `REG_MRVAL) >> 2);
    assign acc = psel & penable;
    assign wr = acc & pwrite;
    assign mapped = (paddr[31:8] == 24'h000000) & (off[1:0] == 2'h0)
        & ((off <= `REG_STAT) | ((off >= `REG_MRVAL) & (off <= `REG_MRVAL_END)));
    assign pready = 1'b1;
    assign pslverr = acc & ~mapped;
    // Termination on before or after the write
    assign rtt_on = (mr_sent[1][`RTT_NOM_HI:`RTT_NOM_LO] != 3'h0)
        | (mr_val[1][`RTT_NOM_HI:`RTT_NOM_LO] != 3'h0);
    assign sel_now = (st == mrs_pkg::C_INIT) ? init_sel(init_idx) : mrs_sel;
    assign exempt = (st == mrs_pkg::C_READY)
        ? ((mr_val[sel_now] ^ mr_sent[sel_now]) & exempt_mask(sel_now)) : 14'h0000;
    // ODT must already be low at the MRS
    assign mrs_go = (pend_mrs | (st == mrs_pkg::C_INIT))
        & (mrd_cnt == 8'h00) & (upd_cnt == 8'h00)
        & cke_q & banks_idle
        & ~(rtt_on & odt);
    assign cmd_go = pend_cmd & ~mrs_go & ~pend_mrs & (st == mrs_pkg::C_READY)
        & cke_q & (mod_cnt == 8'h00) & (upd_cnt == 8'h00);

    // ********************************************
    // Next state
    // ********************************************
    always_comb
    begin
        next_st = st;
        next_mr_val = mr_val;
        next_mr_sent = mr_sent;
        next_mrs_sel = mrs_sel;
        next_init_idx = init_idx;
        next_cke_q = cke_q;
        next_odt_req = odt_req;
        next_pend_mrs = pend_mrs;
        next_pend_cmd = pend_cmd;
        next_refused = refused;
        next_cmd_word = cmd_word;
        next_prdata = prdata;
        next_cs_n = 1'b1;
        next_cmd4 = cmd4;
        next_bgba = bgba;
        next_addr = addr;
        next_mrd_cnt = (mrd_cnt != 8'h00) ? mrd_cnt - 8'h01 : 8'h00;
        next_mod_cnt = (mod_cnt != 8'h00) ? mod_cnt - 8'h01 : 8'h00;
        next_upd_cnt = (upd_cnt != 8'h00) ? upd_cnt - 8'h01 : 8'h00;
        if (psel & ~penable)
        begin
            case (off)
                `REG_CTRL: next_prdata = {28'h0, pend_cmd, 1'b0, odt_req, cke_q};
                `REG_MRS: next_prdata = {13'h0, mrs_sel, 2'h0, mr_val[mrs_sel]};
                `REG_CMD: next_prdata = {10'h0, cmd_word};
                `REG_STAT: next_prdata = {25'h0, upd_cnt != 8'h00, mod_cnt != 8'h00,
                    mrd_cnt != 8'h00, pend_cmd, pend_mrs, refused, st == mrs_pkg::C_READY};
                default: next_prdata = (mapped && vidx <= `MR_LAST)
                    ? {18'h0, mr_val[vidx]} : 32'h0;
            endcase
        end
        if (wr & mapped)
        begin
            case (off)
                `REG_CTRL:
                begin
                    next_cke_q = pwdata[`CTRL_CKE];
                    next_odt_req = pwdata[`CTRL_ODT];
                    if (pwdata[`CTRL_INIT] && st != mrs_pkg::C_INIT)
                    begin
                        next_st = mrs_pkg::C_INIT;
                        next_init_idx = 3'h0;
                        next_pend_mrs = 1'b0;
                    end
                    if (pwdata[`CTRL_CMD])
                    begin
                        if (st == mrs_pkg::C_READY)
                            next_pend_cmd = 1'b1;
                        else
                            next_refused = 1'b1;
                    end
                end
                `REG_MRS:
                begin
                    if (st == mrs_pkg::C_READY && !pend_mrs
                        && pwdata[`MRS_SEL_LO+2:`MRS_SEL_LO] <= `MR_LAST)
                    begin
                        next_mrs_sel = pwdata[`MRS_SEL_LO+2:`MRS_SEL_LO];
                        next_mr_val[pwdata[`MRS_SEL_LO+2:`MRS_SEL_LO]] = pwdata[13:0];
                        next_pend_mrs = 1'b1;
                    end
                    else
                        next_refused = 1'b1;
                end
                `REG_CMD: next_cmd_word = pwdata[21:0];
                `REG_STAT:
                    if (pwdata[`STAT_REFUSED])
                        next_refused = 1'b0;
                default:
                    if (vidx <= `MR_LAST)
                        next_mr_val[vidx] = pwdata[13:0];
            endcase
        end
        if (mrs_go)
        begin
            next_cs_n = 1'b0;
            next_cmd4 = `CMD_MRS;
            next_bgba = {1'b0, sel_now};
            next_addr = mr_val[sel_now];
            next_mr_sent[sel_now] = mr_val[sel_now];
            next_mrd_cnt = 8'(`TMRD_CYC - 1);
            next_mod_cnt = 8'(`TMOD_CYC - 1);
            // Excepted fields settle longer than tMOD
            if (exempt != 14'h0000)
                next_upd_cnt = 8'(`TUPD_CYC - 1);
            if (st == mrs_pkg::C_INIT)
            begin
                next_init_idx = init_idx + 3'h1;
                if (init_idx == `MR_LAST)
                    next_st = mrs_pkg::C_READY;
            end
            else
                next_pend_mrs = 1'b0;
        end
        else if (cmd_go)
        begin
            next_cs_n = 1'b0;
            next_cmd4 = cmd_word[3:0];
            next_bgba = cmd_word[7:4];
            next_addr = cmd_word[21:8];
            next_pend_cmd = 1'b0;
        end
        // Set wins over the software clear
        if (wr && off == `REG_MRS && (st != mrs_pkg::C_READY || pend_mrs))
            next_refused = 1'b1;
        next_odt = odt_req & ~(rtt_on & (pend_mrs | (st != mrs_pkg::C_READY) | mrs_go
            | (next_mod_cnt != 8'h00) | (mod_cnt != 8'h00)));
    end

    // ********************************************
    // Registers
    // ********************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= mrs_pkg::C_UNINIT;
            for (int k = 0; k < `MR_COUNT; k++)
            begin
                mr_val[k] <= 14'h0000;
                mr_sent[k] <= 14'h0000;
            end
            mrs_sel <= 3'h0;
            init_idx <= 3'h0;
            cke_q <= 1'b0;
            odt_req <= 1'b0;
            pend_mrs <= 1'b0;
            pend_cmd <= 1'b0;
            refused <= 1'b0;
            cmd_word <= 22'h000000;
            prdata <= 32'h0;
            cs_n <= 1'b1;
            odt <= 1'b0;
            cmd4 <= 4'hF;
            bgba <= 4'h0;
            addr <= 14'h0000;
            mrd_cnt <= 8'h00;
            mod_cnt <= 8'h00;
            upd_cnt <= 8'h00;
        end
        else
        begin
            st <= next_st;
            mr_val <= next_mr_val;
            mr_sent <= next_mr_sent;
            mrs_sel <= next_mrs_sel;
            init_idx <= next_init_idx;
            cke_q <= next_cke_q;
            odt_req <= next_odt_req;
            pend_mrs <= next_pend_mrs;
            pend_cmd <= next_pend_cmd;
            refused <= next_refused;
            cmd_word <= next_cmd_word;
            prdata <= next_prdata;
            cs_n <= next_cs_n;
            odt <= next_odt;
            cmd4 <= next_cmd4;
            bgba <= next_bgba;
            addr <= next_addr;
            mrd_cnt <= next_mrd_cnt;
            mod_cnt <= next_mod_cnt;
            upd_cnt <= next_upd_cnt;
        end
    end

    assign link.cke = cke_q;
    assign link.cs_n = cs_n;
    assign {link.act_n, link.ras_n, link.cas_n, link.we_n} = cmd4;
    assign link.bg = bgba[3:2];
    assign link.ba = bgba[1:0];
    assign link.addr = addr;
    assign link.odt = odt;
endmodule : mrs_controller

// ==== core/mrs_defines.svh ====
`ifndef MRS_DEFINES_SVH
`define MRS_DEFINES_SVH

// ********************************************
// Mode register geometry
// ********************************************
`define MR_COUNT 7
`define MR_W 14
`define MR_LAST 3'h6

// ********************************************
// Link timing at 20 ns
// ********************************************
`define TCK_NS 20
`define TMRD_NCK 8
`define TMOD_NCK 24
`define TMOD_NS 15
`define TMRD_CYC `TMRD_NCK
`define TMOD_NS_CYC ((`TMOD_NS + `TCK_NS - 1) / `TCK_NS)
`define TMOD_CYC ((`TMOD_NCK > `TMOD_NS_CYC) ? `TMOD_NCK : `TMOD_NS_CYC)
`define TUPD_CYC 64
`define CNT_W 8

// ********************************************
// Field positions
// ********************************************
`define DLL_RST_BIT 8
`define RTT_NOM_HI 10
`define RTT_NOM_LO 8
`define MR1_EXEMPT 14'h0001
`define MR3_EXEMPT 14'h0018
`define MR4_EXEMPT 14'h01D2
`define MR5_EXEMPT 14'h0007
`define MR6_EXEMPT 14'h00FF

// ********************************************
// Command encoding {act_n, ras_n, cas_n, we_n}
// ********************************************
`define CMD_MRS 4'h8

// ********************************************
// APB map of the controller
// ********************************************
`define REG_CTRL 8'h00
`define REG_MRS 8'h04
`define REG_CMD 8'h08
`define REG_STAT 8'h0C
`define REG_MRVAL 8'h10
`define REG_MRVAL_END 8'h28
`define CTRL_CKE 0
`define CTRL_ODT 1
`define CTRL_INIT 2
`define CTRL_CMD 3
`define MRS_SEL_LO 16
`define STAT_REFUSED 1

`endif

// ==== core/mrs_device.sv ====
`timescale 1ns/1ps
`include "mrs_defines.svh"
module mrs_device (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Command link
    ddr4_cmd_if.dram link,
    // Register readback
    input wire logic [2:0] rd_sel,
    output logic [13:0] rd_data,
    output logic [13:0] rd_eff,
    output logic [6:0] written,
    // Status
    output logic mrd_busy,
    output logic mod_busy,
    output logic dll_rst,
    output logic mrd_viol,
    output logic mod_viol,
    output logic odt_viol
);
    // ********************************************
    // Command decode
    // ********************************************
    logic mrs;
    logic other;
    mrs_pkg::mr_sel_t sel;
    mrs_pkg::mr_val_t mr [`MR_COUNT];
    mrs_pkg::mr_val_t eff [`MR_COUNT];
    mrs_pkg::cnt_t mrd_cnt, next_mrd_cnt, mod_cnt, next_mod_cnt;
    logic rtt_on;
    logic [13:0] next_rd_data, next_rd_eff;
    logic next_dll_rst, next_mrd_viol, next_mod_viol, next_odt_viol;

    assign sel = {link.bg[0], link.ba};
    assign mrs = link.cke & ~link.cs_n
        & ({link.act_n, link.ras_n, link.cas_n, link.we_n} == `CMD_MRS);
    assign other = link.cke & ~link.cs_n & ~mrs;
    assign rtt_on = eff[1][`RTT_NOM_HI:`RTT_NOM_LO] != 3'h0;

    // ********************************************
    // Mode registers, one store per entry
    // ********************************************
    // Writes touch only these stores
    genvar i;
    generate
        for (i = 0; i < `MR_COUNT; i++)
        begin : g_mr
            logic hit;
            mrs_pkg::mr_val_t next_mr, next_eff;
            mrs_pkg::cnt_t cnt, next_cnt;
            logic next_wr;
            assign hit = mrs & (sel == 3'(i));
            always_comb
            begin
                next_mr = mr[i];
                next_eff = eff[i];
                next_cnt = cnt;
                next_wr = written[i];
                if (hit)
                begin
                    next_mr = link.addr;
                    next_wr = 1'b1;
                    next_cnt = 8'(`TMOD_CYC - 1);
                end
                else if (cnt != 8'h00)
                    next_cnt = cnt - 8'h01;
                else
                    next_eff = mr[i];
            end
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    mr[i] <= 14'h0000;
                    eff[i] <= 14'h0000;
                    cnt <= 8'h00;
                    written[i] <= 1'b0;
                end
                else
                begin
                    mr[i] <= next_mr;
                    eff[i] <= next_eff;
                    cnt <= next_cnt;
                    written[i] <= next_wr;
                end
            end
        end
    endgenerate

    // ********************************************
    // Spacing checks and status
    // ********************************************
    always_comb
    begin
        next_mrd_cnt = (mrd_cnt != 8'h00) ? mrd_cnt - 8'h01 : 8'h00;
        next_mod_cnt = (mod_cnt != 8'h00) ? mod_cnt - 8'h01 : 8'h00;
        if (mrs)
        begin
            next_mrd_cnt = 8'(`TMRD_CYC - 1);
            next_mod_cnt = 8'(`TMOD_CYC - 1);
        end
        next_mrd_viol = mrs & (mrd_cnt != 8'h00);
        next_mod_viol = other & (mod_cnt != 8'h00);
        next_odt_viol = mrs & rtt_on & link.odt;
        // DLL reset outlasts tMOD
        next_dll_rst = mrs & (sel == 3'h0) & link.addr[`DLL_RST_BIT];
        next_rd_data = (rd_sel <= `MR_LAST) ? mr[rd_sel] : 14'h0000;
        next_rd_eff = (rd_sel <= `MR_LAST) ? eff[rd_sel] : 14'h0000;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mrd_cnt <= 8'h00;
            mod_cnt <= 8'h00;
            mrd_viol <= 1'b0;
            mod_viol <= 1'b0;
            odt_viol <= 1'b0;
            dll_rst <= 1'b0;
            rd_data <= 14'h0000;
            rd_eff <= 14'h0000;
        end
        else
        begin
            mrd_cnt <= next_mrd_cnt;
            mod_cnt <= next_mod_cnt;
            mrd_viol <= next_mrd_viol;
            mod_viol <= next_mod_viol;
            odt_viol <= next_odt_viol;
            dll_rst <= next_dll_rst;
            rd_data <= next_rd_data;
            rd_eff <= next_rd_eff;
        end
    end

    assign mrd_busy = mrd_cnt != 8'h00;
    assign mod_busy = mod_cnt != 8'h00;
endmodule : mrs_device

// ==== core/mrs_pkg.sv ====
package mrs_pkg;
    typedef logic [13:0] mr_val_t;
    typedef logic [2:0] mr_sel_t;
    typedef logic [7:0] cnt_t;
    typedef enum logic [1:0] {C_UNINIT, C_INIT, C_READY} ctl_st_e;
endpackage : mrs_pkg

// ==== tb/ddr4_mode_register_set_test.sv ====
`timescale 1ns/1ps
`include "mrs_defines.svh"
module ddr4_mode_register_set_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, banks_idle = 1'b1;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
    logic pready, pslverr, mrd_busy, mod_busy, dll_rst, mrd_viol, mod_viol, odt_viol;
    logic f_mrd, f_mod, f_odt;
    logic [2:0] rd_sel = 3'h0;
    logic [13:0] rd_data, rd_eff;
    logic [6:0] written;
    logic [33:0] notes [$];
    logic [33:0] note;
    int n_mismatch = 0, cmp_count = 0, n_mrs = 0, n_cmd = 0, gap = 0, last_gap = 0;
    int cmd_gap = 0, n_dll = 0, n_bad = 0, n_fmrd = 0, n_fmod = 0, n_fodt = 0;
    ddr4_cmd_if link ();
    ddr4_cmd_if flink ();
    wire lmrs = link.cke === 1'b1 && link.cs_n === 1'b0
        && {link.act_n, link.ras_n, link.cas_n, link.we_n} === 4'h8;
    wire lcmd = link.cke === 1'b1 && link.cs_n === 1'b0 && !lmrs;
    mrs_controller mrs_controller_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .banks_idle(banks_idle), .link(link));
    mrs_device mrs_device_i (.pclk(pclk), .presetn(presetn), .link(link), .rd_sel(rd_sel),
        .rd_data(rd_data), .rd_eff(rd_eff), .written(written), .mrd_busy(mrd_busy),
        .mod_busy(mod_busy), .dll_rst(dll_rst), .mrd_viol(mrd_viol), .mod_viol(mod_viol),
        .odt_viol(odt_viol));
    // Second device sees a rule-breaking driver
    mrs_device mrs_device_2_i (.pclk(pclk), .presetn(presetn), .link(flink),
        .rd_sel(3'h0), .rd_data(), .rd_eff(), .written(), .mrd_busy(), .mod_busy(),
        .dll_rst(), .mrd_viol(f_mrd), .mod_viol(f_mod), .odt_viol(f_odt));
    mrs_props mrs_props_i (.pclk(pclk), .presetn(presetn), .cke(link.cke),
        .cs_n(link.cs_n), .act_n(link.act_n), .ras_n(link.ras_n), .cas_n(link.cas_n),
        .we_n(link.we_n), .bg(link.bg), .ba(link.ba), .addr(link.addr), .odt(link.odt));
    always #10 pclk = ~pclk;
    // ****************************************
    // Checking and monitors
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wrap_up(input int bad);
        n_mismatch += bad;
        $display("cmp %0d bad %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up
    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1 && notes.size() > 0)
        begin
            note = notes.pop_front();
            check("pslverr", 32'(pslverr), 32'(note[32]));
            if (note[33])
                check("prdata", prdata, note[31:0]);
        end
        gap <= gap + 1;
        if (lmrs)
        begin
            n_mrs <= n_mrs + 1;
            last_gap <= gap;
            gap <= 1;
        end
        if (lcmd)
        begin
            n_cmd <= n_cmd + 1;
            cmd_gap <= gap;
        end
        n_dll <= n_dll + (dll_rst === 1'b1);
        n_bad <= n_bad + (presetn
            && (mrd_viol !== 1'b0 || mod_viol !== 1'b0 || odt_viol !== 1'b0));
        n_fmrd <= n_fmrd + (f_mrd === 1'b1);
        n_fmod <= n_fmod + (f_mod === 1'b1);
        n_fodt <= n_fodt + (f_odt === 1'b1);
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [33:0] n);
        int k;
        k = 0;
        notes.push_back(n);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 50)
        begin
            k++;
            @(posedge pclk);
        end
        if (k >= 50)
            wrap_up(1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 34'h0);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] d);
        apb(1'b0, a, d, {2'b10, d});
    endtask : rd
    task automatic wait_ev(input bit c, input int n);
        int k;
        k = 0;
        while ((c ? n_cmd : n_mrs) < n && k < 300)
        begin
            k++;
            @(posedge pclk);
        end
        if (k >= 300)
            wrap_up(1);
    endtask : wait_ev
    // Idle address is random so stale values show
    task automatic fdrv(input logic c_n, input logic [3:0] c, input logic [2:0] s,
        input logic [13:0] a, input logic o);
        flink.cke <= 1'b1;
        flink.cs_n <= c_n;
        {flink.act_n, flink.ras_n, flink.cas_n, flink.we_n} <= c;
        flink.bg <= {1'b0, s[2]};
        flink.ba <= s[1:0];
        flink.addr <= c_n ? 14'($urandom) : a;
        flink.odt <= o;
        @(posedge pclk);
    endtask : fdrv
    task automatic fidle(input int n);
        repeat (n) fdrv(1'b1, 4'hF, 3'($urandom), 14'h0, 1'b0);
    endtask : fidle
    // ****************************************
    // Scenarios
    // ****************************************
    initial
    begin
        logic [13:0] mv [7];
        logic [13:0] nv;
        void'($urandom(69954));
        fdrv(1'b1, 4'hF, 3'h0, 14'h0, 1'b0);
        repeat (11) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check("idle cs_n", 32'(link.cs_n), 32'h1);
        rd(`REG_STAT, 32'h0);
        for (int i = 0; i < 7; i++)
        begin
            mv[i] = 14'($urandom);
            wr(`REG_MRVAL + 8'(4 * i), 32'(mv[i]));
        end
        mv[1][10:8] = 3'h1;
        mv[0][8] = 1'b1;
        wr(`REG_MRVAL + 8'h04, 32'(mv[1]));
        wr(`REG_MRVAL, 32'(mv[0]));
        wr(`REG_CTRL, 32'h3);
        wr(`REG_CTRL, 32'h7);
        wait_ev(1'b0, 7);
        repeat (70) @(posedge pclk);
        check("written", 32'(written), 32'h7F);
        check("dll pulses", n_dll, 1);
        check("odt", 32'(link.odt), 32'h1);
        rd(`REG_STAT, 32'h1);
        rd(`REG_MRVAL + 8'h04, 32'(mv[1]));
        for (int i = 0; i < 7; i++)
        begin
            rd_sel <= 3'(i);
            repeat (2) @(posedge pclk);
            check("rd_data", 32'(rd_data), 32'(mv[i]));
            check("rd_eff", 32'(rd_eff), 32'(mv[i]));
        end
        banks_idle <= 1'b0;
        rd_sel <= 3'h2;
        nv = mv[2] ^ 14'(32'h0001 << ($urandom % 14));
        wr(`REG_MRS, {13'h0, 3'h2, 2'b00, nv});
        repeat (20) @(posedge pclk);
        check("held mrs", n_mrs, 7);
        banks_idle <= 1'b1;
        wait_ev(1'b0, 8);
        repeat (2) @(posedge pclk);
        check("busy", 32'({mrd_busy, mod_busy}), 32'h3);
        check("stored", 32'(rd_data), 32'(nv));
        check("old eff", 32'(rd_eff), 32'(mv[2]));
        repeat (26) @(posedge pclk);
        check("new eff", 32'(rd_eff), 32'(nv));
        check("idle", 32'({mrd_busy, mod_busy}), 32'h0);
        wr(`REG_MRS, {13'h0, 3'h4, 2'b00, mv[4]});
        wait_ev(1'b0, 9);
        wr(`REG_MRS, {13'h0, 3'h5, 2'b00, mv[5]});
        wait_ev(1'b0, 10);
        wr(`REG_CMD, 32'h0004000E);
        wr(`REG_CTRL, 32'hB);
        wait_ev(1'b1, 1);
        check("mrd gap", 32'(last_gap >= 8), 32'h1);
        check("mod gap", 32'(cmd_gap >= 24), 32'h1);
        wr(`REG_MRS, {13'h0, 3'h3, 2'b00, mv[3] ^ 14'h0008});
        wait_ev(1'b0, 11);
        wr(`REG_MRS, {13'h0, 3'h2, 2'b00, nv});
        wait_ev(1'b0, 12);
        check("long gap", 32'(last_gap >= 64), 32'h1);
        wr(`REG_MRS, {13'h0, 3'h7, 2'b00, nv});
        repeat (80) @(posedge pclk);
        check("refused mrs", n_mrs, 12);
        rd(`REG_STAT, 32'h3);
        wr(`REG_STAT, 32'h2);
        rd(`REG_STAT, 32'h1);
        apb(1'b0, 8'h40, 32'h0, {2'b01, 32'h0});
        check("clean link", n_bad, 0);
        fdrv(1'b0, 4'h8, 3'h1, 14'h0100, 1'b0);
        fidle(3);
        fdrv(1'b0, 4'h8, 3'h2, 14'h0000, 1'b0);
        fidle(4);
        fdrv(1'b0, 4'hE, 3'h0, 14'h0400, 1'b0);
        fidle(40);
        fdrv(1'b0, 4'h8, 3'h1, 14'h0100, 1'b1);
        fidle(4);
        check("mrd fault", n_fmrd, 1);
        check("mod fault", n_fmod, 1);
        check("odt fault", n_fodt, 1);
        wrap_up(0);
    end
endmodule : ddr4_mode_register_set_test

// ==== tb/mrs_props.sv ====
`timescale 1ns/1ps
module mrs_props (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Command link
    input wire logic cke,
    input wire logic cs_n,
    input wire logic act_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [1:0] bg,
    input wire logic [1:0] ba,
    input wire logic [13:0] addr,
    input wire logic odt
);
    localparam logic [2:0] init_seq [7] = '{3'h3, 3'h6, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0};
    logic cmd, mrs, hot_now, rtt, hot, next_rtt, next_hot;
    logic [7:0] gap, next_gap;
    logic [2:0] idx, next_idx;
    assign cmd = cke && !cs_n;
    assign mrs = cmd && ({act_n, ras_n, cas_n, we_n} == 4'h8);
    // Old or new MR1 termination
    assign hot_now = rtt || ({bg[0], ba} == 3'h1 && addr[10:8] != 3'h0);
    always_comb
    begin
        next_gap = (gap == 8'hFF) ? gap : gap + 8'h01;
        next_idx = idx;
        next_rtt = rtt;
        next_hot = hot;
        if (mrs)
        begin
            next_gap = 8'h01;
            next_idx = (idx == 3'h7) ? idx : idx + 3'h1;
            next_hot = hot_now;
            if ({bg[0], ba} == 3'h1)
                next_rtt = addr[10:8] != 3'h0;
        end
    end
    // Saturated gap makes the first MRS legal
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gap <= 8'hFF;
            idx <= 3'h0;
            rtt <= 1'b0;
            hot <= 1'b0;
        end
        else
        begin
            gap <= next_gap;
            idx <= next_idx;
            rtt <= next_rtt;
            hot <= next_hot;
        end
    end
    // ****************************************
    // Link timing and order
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence mrs_s;
        mrs;
    endsequence
    sequence other_s;
        cmd && !mrs;
    endsequence
    mrs_space_a: assert property (mrs_s |=> !mrs [*7])
        else $error("MRS too close");
    mrs_gap_a: assert property (mrs_s |-> gap >= 8'h08)
        else $error("MRS gap short");
    mod_gap_a: assert property (other_s |-> gap >= 8'h18)
        else $error("command before tMOD");
    mrs_cke_a: assert property (mrs_s |-> $past(cke))
        else $error("MRS without CKE");
    cke_off_a: assert property (!cke |-> cs_n)
        else $error("command with CKE low");
    odt_pre_a: assert property (mrs_s ##0 hot_now |-> !odt && !$past(odt))
        else $error("ODT high at MRS");
    odt_post_a: assert property (odt |-> !hot || gap >= 8'h18)
        else $error("ODT high in tMOD");
    init_order_a: assert property (mrs_s ##0 (idx < 3'h7) |-> {bg[0], ba} == init_seq[idx])
        else $error("init MRS out of order");
    init_full_a: assert property (other_s |-> idx == 3'h7)
        else $error("command before init");
endmodule : mrs_props
